/* hdl/i2spc_defs.svh */
`ifndef I2SPC_DEFS_SVH
`define I2SPC_DEFS_SVH

// register byte offsets
`define I2SPC_OFF_CTRL     12'h000
`define I2SPC_OFF_STATUS   12'h004
`define I2SPC_OFF_CLEAR    12'h008
`define I2SPC_OFF_MASK     12'h00c
`define I2SPC_OFF_BAUD     12'h010
`define I2SPC_ADDR_W       12

// control fields
`define I2SPC_CTRL_GEN     0
`define I2SPC_CTRL_XFER    1
`define I2SPC_CTRL_INV     2
`define I2SPC_CTRL_FALLIE  4
`define I2SPC_CTRL_RISEIE  5
`define I2SPC_CTRL_ENDIE   6
`define I2SPC_CTRL_TRIGIE  15
`define I2SPC_CTRL_DEL_LO  16
`define I2SPC_CTRL_DEL_HI  21
`define I2SPC_CTRL_MCLK    31
`define I2SPC_CTRL_WMASK   32'h803f_8077
`define I2SPC_CTRL_RESET   32'h0000_0000

// status fields
`define I2SPC_ST_WS        0
`define I2SPC_ST_SELIN     1
`define I2SPC_ST_TRIG      3
`define I2SPC_ST_FALL      4
`define I2SPC_ST_RISE      5
`define I2SPC_ST_END       6
`define I2SPC_ST_STICKY    32'h0000_0078

// baud fields: base divider, prescale and divide quanta
`define I2SPC_BAUD_DIV_HI  7
`define I2SPC_BAUD_PQ_LO   8
`define I2SPC_BAUD_PQ_HI   9
`define I2SPC_BAUD_DQ_LO   10
`define I2SPC_BAUD_DQ_HI   15
`define I2SPC_BAUD_WMASK   32'h0000_ffff
`define I2SPC_BAUD_RESET   32'h0000_0000

`define I2SPC_RESP_OKAY    2'b00
`define I2SPC_RESP_SLVERR  2'b10

`endif

/* hdl/i2spc_pkg.sv */
package i2spc_pkg;

  typedef enum logic [2:0] {
    I2SPC_IDLE  = 3'b001,
    I2SPC_RUN   = 3'b010,
    I2SPC_DRAIN = 3'b100
  } i2spc_gen_state_t;

endpackage : i2spc_pkg

/* hdl/i2spc_core.sv */
// How it works
// - generation off: word select held low
// - generated word select starts low
// - generation on forces master clock running
// - stops toggling within one period
// - transfer enable gates frame starts
// - inversion bit sets select output polarity
// - falling edge interrupt when enabled
// - rising edge interrupt when enabled
// - end interrupt after full word
// - trigger flag and interrupt when enabled
// - transfer delay, zero means one cycle
// - master clock enable, else held low
// - reserved control bits read zero
// - edge flags set on generated edges
// - flags held until written one
// - word select toggles every N cycles
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "i2spc_defs.svh"

module i2spc_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        select_in,
  input  wire logic        select_input_trigger,
  output logic             select_outputs,
  output logic             shift_clk_out,
  output logic             master_clk_out,
  output logic             frame_start,
  output logic             frame_channel,
  output logic             irq
);

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strb_mask

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `I2SPC_OFF_CTRL) || (a == `I2SPC_OFF_STATUS) || (a == `I2SPC_OFF_CLEAR) ||
                 (a == `I2SPC_OFF_MASK) || (a == `I2SPC_OFF_BAUD);
  endfunction : addr_known

  // ---------------- bus slave ----------------
  logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic        awready_q, wready_q, arready_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] ctrl_q, mask_q, baud_q, flags_q;

  wire        aw_take  = s_axi_awvalid & awready_q;
  wire        w_take   = s_axi_wvalid & wready_q;
  wire        ar_take  = s_axi_arvalid & arready_q;
  wire        do_write = aw_hold_q & w_hold_q & ~bvalid_q;
  wire [31:0] wbits    = wdata_q & strb_mask(wstrb_q);
  wire        wr_ctrl  = do_write & (awaddr_q == `I2SPC_OFF_CTRL);
  wire        wr_stat  = do_write & (awaddr_q == `I2SPC_OFF_STATUS);
  wire        wr_clr   = do_write & (awaddr_q == `I2SPC_OFF_CLEAR);
  wire        wr_mask  = do_write & (awaddr_q == `I2SPC_OFF_MASK);
  wire        wr_baud  = do_write & (awaddr_q == `I2SPC_OFF_BAUD);
  wire [31:0] wmask    = strb_mask(wstrb_q);

  wire aw_hold_d = aw_hold_q ? ~do_write : aw_take;
  wire w_hold_d  = w_hold_q ? ~do_write : w_take;
  wire bvalid_d  = do_write | (bvalid_q & ~s_axi_bready);
  wire rvalid_d  = ar_take | (rvalid_q & ~s_axi_rready);

  wire [31:0] rd_mux =
    (s_axi_araddr == `I2SPC_OFF_CTRL)   ? (ctrl_q & `I2SPC_CTRL_WMASK) :
    (s_axi_araddr == `I2SPC_OFF_STATUS) ? flags_q :
    (s_axi_araddr == `I2SPC_OFF_MASK)   ? mask_q :
    (s_axi_araddr == `I2SPC_OFF_BAUD)   ? baud_q : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bresp_q   <= `I2SPC_RESP_OKAY;
      rresp_q   <= `I2SPC_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q  <= ~w_hold_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) bresp_q <= addr_known(awaddr_q) ? `I2SPC_RESP_OKAY : `I2SPC_RESP_SLVERR;
      if (ar_take) begin
        rdata_q <= rd_mux;
        rresp_q <= addr_known(s_axi_araddr) ? `I2SPC_RESP_OKAY : `I2SPC_RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // reserved control bits never store, so they read back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `I2SPC_CTRL_RESET;
      mask_q <= 32'h0000_0000;
      baud_q <= `I2SPC_BAUD_RESET;
    end else begin
      if (wr_ctrl) ctrl_q <= (ctrl_q & ~wmask) | (wbits & `I2SPC_CTRL_WMASK);
      if (wr_mask) mask_q <= (mask_q & ~wmask) | (wbits & `I2SPC_ST_STICKY);
      if (wr_baud) baud_q <= (baud_q & ~wmask) | (wbits & `I2SPC_BAUD_WMASK);
    end
  end

  wire       gen_en   = ctrl_q[`I2SPC_CTRL_GEN];
  wire       xfer_en  = ctrl_q[`I2SPC_CTRL_XFER];
  wire       sel_inv  = ctrl_q[`I2SPC_CTRL_INV];
  wire       mclk_en  = ctrl_q[`I2SPC_CTRL_MCLK];
  wire [5:0] xfer_del = ctrl_q[`I2SPC_CTRL_DEL_HI:`I2SPC_CTRL_DEL_LO];
  wire [7:0] base_div = baud_q[`I2SPC_BAUD_DIV_HI:0];
  wire [1:0] pq       = baud_q[`I2SPC_BAUD_PQ_HI:`I2SPC_BAUD_PQ_LO];
  wire [5:0] dq       = baud_q[`I2SPC_BAUD_DQ_HI:`I2SPC_BAUD_DQ_LO];

  // ---------------- clock dividers ----------------
  logic [7:0] base_cnt_q;
  logic       phase_q, sclk_q, mclk_q;
  i2spc_pkg::i2spc_gen_state_t state_q, state_d;

  wire gen_busy  = (state_q != i2spc_pkg::I2SPC_IDLE);
  wire mclk_run  = gen_en | gen_busy | mclk_en;
  wire sclk_run  = gen_en | gen_busy | xfer_en;
  wire base_tick = (base_cnt_q == base_div);
  wire sclk_fall = base_tick & phase_q & sclk_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_cnt_q <= 8'h00;
      phase_q    <= 1'b0;
      sclk_q     <= 1'b0;
      mclk_q     <= 1'b0;
    end else begin
      base_cnt_q <= base_tick ? 8'h00 : base_cnt_q + 8'h01;
      if (!mclk_run) mclk_q <= 1'b0;
      else if (base_tick) mclk_q <= ~mclk_q;
      if (!sclk_run) begin
        phase_q <= 1'b0;
        sclk_q  <= 1'b0;
      end else if (base_tick) begin
        phase_q <= ~phase_q;
        if (phase_q) sclk_q <= ~sclk_q;
      end
    end
  end

  // ---------------- word select generation ----------------
  logic [8:0] word_cnt_q, word_cnt_d;
  logic       ws_q, ws_d, end_pulse;

  // worst case (3+1)*(63+1)=256 cycles, fits nine bits
  wire [8:0] word_last = 9'(({7'h00, pq} + 9'h001) * ({3'h0, dq} + 9'h001) - 9'h001);
  wire       word_end  = sclk_fall & (word_cnt_q == word_last);

  always_comb begin
    state_d    = state_q;
    ws_d       = ws_q;
    word_cnt_d = word_cnt_q;
    end_pulse  = 1'b0;
    case (state_q)
      i2spc_pkg::I2SPC_IDLE: begin
        ws_d       = 1'b0;
        word_cnt_d = 9'h000;
        if (gen_en) state_d = i2spc_pkg::I2SPC_RUN;
      end
      i2spc_pkg::I2SPC_RUN: begin
        if (word_end) begin
          word_cnt_d = 9'h000;
          ws_d       = ~ws_q;
        end else if (sclk_fall) begin
          word_cnt_d = word_cnt_q + 9'h001;
        end
        if (!gen_en) state_d = i2spc_pkg::I2SPC_DRAIN;
      end
      i2spc_pkg::I2SPC_DRAIN: begin
        // finish the current word, then park low; at most one period
        if (word_end) begin
          word_cnt_d = 9'h000;
          ws_d       = 1'b0;
          end_pulse  = 1'b1;
          state_d    = i2spc_pkg::I2SPC_IDLE;
        end else if (sclk_fall) begin
          word_cnt_d = word_cnt_q + 9'h001;
        end
      end
      default: begin
        state_d    = i2spc_pkg::I2SPC_IDLE;
        ws_d       = 1'b0;
        word_cnt_d = 9'h000;
      end
    endcase
  end

  wire ws_fall = ws_q & ~ws_d;
  wire ws_rise = ~ws_q & ws_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= i2spc_pkg::I2SPC_IDLE;
      ws_q       <= 1'b0;
      word_cnt_q <= 9'h000;
    end else begin
      state_q    <= state_d;
      ws_q       <= ws_d;
      word_cnt_q <= word_cnt_d;
    end
  end

  // ---------------- pin inputs ----------------
  logic [1:0] selin_sync_q, trig_sync_q;
  logic       trig_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selin_sync_q <= 2'b00;
      trig_sync_q  <= 2'b00;
      trig_prev_q  <= 1'b0;
    end else begin
      selin_sync_q <= {selin_sync_q[0], select_in};
      trig_sync_q  <= {trig_sync_q[0], select_input_trigger};
      trig_prev_q  <= trig_sync_q[1];
    end
  end
  wire trig_rise = trig_sync_q[1] & ~trig_prev_q;
  // ---------------- frame transfer start ----------------
  logic       ws_src_prev_q, pend_q, ch_q, fs_q;
  logic [6:0] del_cnt_q;
  // own generator is the word select source while it runs
  wire ws_src    = gen_busy ? ws_q : selin_sync_q[1];
  wire ws_change = ws_src ^ ws_src_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_src_prev_q <= 1'b0;
      pend_q        <= 1'b0;
      ch_q          <= 1'b0;
      fs_q          <= 1'b0;
      del_cnt_q     <= 7'h00;
    end else begin
      ws_src_prev_q <= ws_src;
      fs_q          <= 1'b0;
      if (!xfer_en) begin
        pend_q <= 1'b0;
      end else if (ws_change) begin
        pend_q    <= 1'b1;
        ch_q      <= ws_src;
        del_cnt_q <= {1'b0, xfer_del} + 7'h01;
      end else if (pend_q && sclk_fall) begin
        if (del_cnt_q == 7'h01) begin
          pend_q <= 1'b0;
          fs_q   <= 1'b1;
        end
        del_cnt_q <= del_cnt_q - 7'h01;
      end
    end
  end
  // ---------------- status, interrupt, outputs ----------------
  logic [3:0] sticky_q;
  logic       sel_out_q, irq_q;
  wire [3:0] ev_set = {end_pulse, ws_rise, ws_fall, trig_rise};
  wire [31:0] clr_bits = (wr_stat | wr_clr) ? wbits : 32'h0000_0000;
  wire [3:0] ev_clr = clr_bits[`I2SPC_ST_END:`I2SPC_ST_TRIG];
  wire [3:0] ev_en  = {ctrl_q[`I2SPC_CTRL_ENDIE], ctrl_q[`I2SPC_CTRL_RISEIE],
                       ctrl_q[`I2SPC_CTRL_FALLIE], ctrl_q[`I2SPC_CTRL_TRIGIE]};
  wire [3:0] ev_msk = mask_q[`I2SPC_ST_END:`I2SPC_ST_TRIG];
  wire [3:0] sticky_d = (sticky_q & ~ev_clr) | ev_set;  // set wins over clear
  assign flags_q = {25'h0, sticky_q, 1'b0, selin_sync_q[1], ch_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sticky_q  <= 4'h0;
      sel_out_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      sticky_q  <= sticky_d;
      sel_out_q <= ws_d ^ sel_inv;
      irq_q     <= |(sticky_d & ev_en & ev_msk);
    end
  end
  assign select_outputs = sel_out_q;
  assign shift_clk_out  = sclk_q;
  assign master_clk_out = mclk_q;
  assign frame_start    = fs_q;
  assign frame_channel  = ch_q;
  assign irq            = irq_q;
  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // inversion may change while idle, so compare with the bit that launched the output
  property p_idle_low;
    (state_q == i2spc_pkg::I2SPC_IDLE) && !gen_en |=> !ws_q && (select_outputs == $past(sel_inv));
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("word select not low while idle");
  property p_start_low;
    (state_q == i2spc_pkg::I2SPC_IDLE) && gen_en |=> (state_q == i2spc_pkg::I2SPC_RUN) && !ws_q;
  endproperty
  a_start_low: assert property (p_start_low) else $error("generation did not start low");
  property p_mclk_off;
    !mclk_run ##1 !mclk_run |-> !master_clk_out;
  endproperty
  a_mclk_off: assert property (p_mclk_off) else $error("master clock not held low");
  property p_mclk_gen;
    gen_en && base_tick |=> master_clk_out != $past(master_clk_out);
  endproperty
  a_mclk_gen: assert property (p_mclk_gen) else $error("master clock idle during generation");
  property p_drain_end;
    (state_q == i2spc_pkg::I2SPC_DRAIN) && word_end |=> (state_q == i2spc_pkg::I2SPC_IDLE) && sticky_q[3] && !ws_q;
  endproperty
  a_drain_end: assert property (p_drain_end) else $error("generation did not stop at word end");
  property p_no_frame;
    !xfer_en |=> !pend_q ##1 !frame_start;
  endproperty
  a_no_frame: assert property (p_no_frame) else $error("frame started while transfers off");
  property p_edge_flag;
    (ws_fall || ws_rise) |=> (sticky_q[1] || sticky_q[2]);
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag missing");
  // a clear in the same cycle legally drops the flag, so look at the next flag value
  property p_irq_fall;
    sticky_d[1] && ctrl_q[`I2SPC_CTRL_FALLIE] && mask_q[`I2SPC_ST_FALL] |=> irq;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("falling edge interrupt missing");
  property p_toggle_period;
    (state_q == i2spc_pkg::I2SPC_RUN) && sclk_fall && (word_cnt_q != word_last) |=> ws_q == $past(ws_q);
  endproperty
  a_toggle_period: assert property (p_toggle_period) else $error("word select toggled early");

endmodule : i2spc_core

/* verification/i2spc_codec_model.sv */
module i2spc_codec_model (
  input  wire logic aclk,
  output logic      select_in,
  output logic      select_input_trigger
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    select_in            = 1'b0;
    select_input_trigger = 1'b0;
  end

  // codec lines only move just after an edge, never mid-cycle
  task automatic flip_ws();
    @(posedge aclk);
    select_in <= ~select_in;
  endtask : flip_ws

  // hold sets how slowly the codec drops its trigger
  task automatic pulse_trig(input int hold);
    @(posedge aclk);
    select_input_trigger <= 1'b1;
    repeat (hold) @(posedge aclk);
    select_input_trigger <= 1'b0;
  endtask : pulse_trig
endmodule : i2spc_codec_model

/* verification/i2s_protocol_control_tb_top.sv */
`include "i2spc_defs.svh"

module i2s_protocol_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [11:0] s_axi_awaddr  = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [11:0] s_axi_araddr  = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        select_in;
  logic        select_input_trigger;
  logic        select_outputs;
  logic        shift_clk_out;
  logic        master_clk_out;
  logic        frame_start;
  logic        frame_channel;
  logic        irq;
  int          fails       = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          a;
  int          b;
  int          c;
  logic [31:0] d;

  always #4 aclk = ~aclk;

  i2spc_core i_i2spc_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .select_in,
    .select_input_trigger, .select_outputs, .shift_clk_out, .master_clk_out, .frame_start, .frame_channel, .irq);

  i2spc_codec_model i_i2spc_codec_model (.aclk, .select_in, .select_input_trigger);

  task automatic conclude();
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= dt;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [11:0] ad, output logic [31:0] dt, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dt = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er);
  endtask : rd

  // counts select output changes, master clock changes and frame pulses
  task automatic watch(input int n, output int so, output int mc, output int fs);
    logic pso;
    logic pmc;
    so  = 0;
    mc  = 0;
    fs  = 0;
    pso = select_outputs;
    pmc = master_clk_out;
    repeat (n) begin
      @(posedge aclk);
      if (select_outputs !== pso) so++;
      if (master_clk_out !== pmc) mc++;
      if (frame_start === 1'b1) fs++;
      pso = select_outputs;
      pmc = master_clk_out;
    end
  endtask : watch

  // frm picks frame pulse, else next select output change; bounded wait
  task automatic wait_change(input bit frm, output int n);
    logic p;
    p = select_outputs;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (n < 300 && (frm ? frame_start !== 1'b1 : select_outputs === p));
    if (n >= 300) begin
      fails++;
      $display("ERROR %0t wait expired", $time);
    end
  endtask : wait_change

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : chk_irq

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      $display("ERROR %0t run too long", $time);
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({27'h0, shift_clk_out, master_clk_out, frame_start, frame_channel, irq}, 32'h0);
    rd(`I2SPC_OFF_CTRL, d, `I2SPC_RESP_OKAY);
    chk(d, `I2SPC_CTRL_RESET);
    chk({31'h0, select_outputs}, 32'h0);
    wr(`I2SPC_OFF_CTRL, 32'hffff_fff8, `I2SPC_RESP_OKAY);
    rd(`I2SPC_OFF_CTRL, d, `I2SPC_RESP_OKAY);
    chk(d, 32'h803f_8070);
    wr(`I2SPC_OFF_CTRL, 32'h0000_0000, `I2SPC_RESP_OKAY);
    rd(12'h020, d, `I2SPC_RESP_SLVERR);
    chk(d, 32'h0000_0000);
    wr(12'h020, 32'h0000_0001, `I2SPC_RESP_SLVERR);
    // master clock alone: base tick every aclk with divider 0
    wr(`I2SPC_OFF_CTRL, 32'h8000_0000, `I2SPC_RESP_OKAY);
    watch(16, a, b, c);
    chk(b, 16);
    wr(`I2SPC_OFF_CTRL, 32'h0000_0000, `I2SPC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    watch(16, a, b, c);
    chk(b, 0);
    chk({31'h0, master_clk_out}, 32'h0);
    // master run, N = 2 * 2 shift cycles of 4 aclk each; first toggle 16 edges after the write
    wr(`I2SPC_OFF_BAUD, 32'h0000_0500, `I2SPC_RESP_OKAY);
    wr(`I2SPC_OFF_MASK, 32'h0000_0078, `I2SPC_RESP_OKAY);
    wr(`I2SPC_OFF_CTRL, 32'h0000_0075, `I2SPC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk({31'h0, select_outputs}, 32'h1);
    watch(8, a, b, c);
    chk({31'h0, b > 0}, 32'h1);
    wait_change(1'b0, a);
    chk({31'h0, select_outputs}, 32'h0);
    rd(`I2SPC_OFF_STATUS, d, `I2SPC_RESP_OKAY);
    chk(d & 32'h30, 32'h20);
    chk_irq(1'b1);
    wait_change(1'b0, a);
    wait_change(1'b0, a);
    chk(a, 16);
    // stop: the word completes and the line parks
    wr(`I2SPC_OFF_CTRL, 32'h0000_0040, `I2SPC_RESP_OKAY);
    repeat (70) @(posedge aclk);
    watch(40, a, b, c);
    chk(a, 0);
    rd(`I2SPC_OFF_STATUS, d, `I2SPC_RESP_OKAY);
    chk(d & 32'h70, 32'h70);
    chk_irq(1'b1);
    wr(`I2SPC_OFF_CTRL, 32'h0000_0000, `I2SPC_RESP_OKAY);
    chk_irq(1'b0);
    wr(`I2SPC_OFF_CTRL, 32'h0000_0010, `I2SPC_RESP_OKAY);
    chk_irq(1'b1);
    wr(`I2SPC_OFF_CLEAR, 32'h0000_0000, `I2SPC_RESP_OKAY);
    rd(`I2SPC_OFF_STATUS, d, `I2SPC_RESP_OKAY);
    chk(d & 32'h70, 32'h70);
    wr(`I2SPC_OFF_CLEAR, 32'h0000_0070, `I2SPC_RESP_OKAY);
    rd(`I2SPC_OFF_STATUS, d, `I2SPC_RESP_OKAY);
    chk(d & 32'h78, 32'h00);
    chk_irq(1'b0);
    // trigger seen with its enable off, then enabled
    wr(`I2SPC_OFF_CTRL, 32'h0000_0000, `I2SPC_RESP_OKAY);
    i_i2spc_codec_model.pulse_trig(3);
    chk_irq(1'b0);
    rd(`I2SPC_OFF_STATUS, d, `I2SPC_RESP_OKAY);
    chk(d & 32'h08, 32'h08);
    wr(`I2SPC_OFF_CTRL, 32'h0000_8000, `I2SPC_RESP_OKAY);
    chk_irq(1'b1);
    wr(`I2SPC_OFF_CLEAR, 32'h0000_0008, `I2SPC_RESP_OKAY);
    chk_irq(1'b0);
    // slave side: input changes gated, then delayed by the delay field
    wr(`I2SPC_OFF_CTRL, 32'h0000_0000, `I2SPC_RESP_OKAY);
    i_i2spc_codec_model.flip_ws();
    watch(40, a, b, c);
    chk(c, 0);
    chk({31'h0, select_outputs}, 32'h0);
    wr(`I2SPC_OFF_CTRL, 32'h0000_0002, `I2SPC_RESP_OKAY);
    i_i2spc_codec_model.flip_ws();
    wait_change(1'b1, a);
    chk({31'h0, a >= 3 && a <= 10}, 32'h1);
    chk({31'h0, frame_channel}, 32'h0);
    wr(`I2SPC_OFF_CTRL, 32'h0002_0002, `I2SPC_RESP_OKAY);
    i_i2spc_codec_model.flip_ws();
    wait_change(1'b1, a);
    chk({31'h0, a >= 11 && a <= 18}, 32'h1);
    chk({31'h0, frame_channel}, 32'h1);
    conclude();
  end
endmodule : i2s_protocol_control_tb_top
